// *** common/csf_defs.svh ***
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_STATUS_ADDR 8'h18
`define CSF_RESULT_ADDR0 8'h00
`define CSF_CHAN_HI 15
`define CSF_CHAN_LO 14
`define CSF_UR_BIT 13
`define CSF_OR_BIT 12
`define CSF_WD_BIT 11
`define CSF_AH_BIT 10
`define CSF_AL_BIT 9
`define CSF_ZC_BIT 8
`define CSF_RDY_BIT 6
`define CSF_ERR_TYPES 6
`define CSF_CHANNELS 4
`define CSF_STATUS_RESET 16'h0000
`endif

// *** common/csf_pkg.sv ***
package csf_pkg;
    // Error vector order: UR, OR, WD, AH, AL, ZC (msb first)
    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic [5:0] errors;
    } csf_conv_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
    } csf_read_t;

    typedef struct packed {
        logic [5:0] errIntEnable;
        logic readyIntEnable;
        logic sequential;
        logic [3:0] activeMask;
    } csf_cfg_t;

    typedef enum logic [0:0] {CSF_IDLE, CSF_WAIT_ALL} csf_seq_t;
endpackage : csf_pkg

// *** verilog/csf_pending_bits.sv ***
`include "csf_defs.svh"
module csf_pending_bits (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Set and clear per channel
    input wire logic [3:0] setMask,
    input wire logic [3:0] clearMask,
    // State
    output logic [3:0] pending
);
    import csf_pkg::*;

    wire [3:0] next_pending = setMask | (pending & ~clearMask);

    // Set wins over a read in the same cycle: new result stays unread
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pending <= 4'h0;
        end else begin
            pending <= next_pending;
        end
    end

    a_pending_set: assert property (@(posedge ref_clk) disable iff (reset)
        setMask[0] |=> pending[0]) else $error("pending bit not set");
    a_pending_clear: assert property (@(posedge ref_clk) disable iff (reset)
        clearMask[1] && !setMask[1] |=> !pending[1])
        else $error("pending bit not cleared");
endmodule : csf_pending_bits

// *** verilog/conversion_status_flags.sv ***
`include "csf_defs.svh"
module conversion_status_flags (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Conversion results from the core
    input wire csf_pkg::csf_conv_t conv,
    // Register reads decoded by the serial interface
    input wire csf_pkg::csf_read_t rd,
    // Configuration from other registers
    input wire csf_pkg::csf_cfg_t cfg,
    // Status word and interrupt
    output logic [15:0] conversion_status,
    output logic irq_out_n
);
    import csf_pkg::*;

    logic [5:0] errFlags;
    logic [1:0] error_source_channel;
    logic result_ready_flag;
    logic [3:0] seenMask;
    logic [3:0] pendingBits;

    function automatic logic [3:0] chanBit(input logic [1:0] ch);
        chanBit = 4'h1 << ch;
    endfunction : chanBit

    // Read decode
    wire statusRead = rd.valid && rd.addr == `CSF_STATUS_ADDR;
    wire resultRead = rd.valid && rd.addr[7:2] == 6'(`CSF_RESULT_ADDR0 >> 2);
    wire [1:0] readChan = rd.addr[1:0];
    wire [3:0] resultReadMask = resultRead ? chanBit(readChan) : 4'h0;

    // Only enabled types on an active channel are recorded
    wire convActive = conv.valid && cfg.activeMask[conv.channel];
    wire [5:0] newErr = convActive ? (conv.errors & cfg.errIntEnable) : 6'h00;
    wire anyNewErr = |newErr;
    // Source channel result read also releases the latch
    wire releaseErr = statusRead ||
        (resultRead && readChan == error_source_channel);

    wire [5:0] next_errFlags = newErr | (releaseErr ? 6'h00 : errFlags);

    // Keep the first source while something is latched so the code matches the flags
    wire holdChan = |errFlags && !releaseErr;
    wire [1:0] next_chan = (anyNewErr && !holdChan) ? conv.channel :
        error_source_channel;

    // Sequencing: in sequential mode, collect every active channel before raising ready
    wire [3:0] convSetMask = convActive ? chanBit(conv.channel) : 4'h0;
    wire [3:0] next_seenCombined = seenMask | convSetMask;
    wire allSeen = (next_seenCombined & cfg.activeMask) == cfg.activeMask;
    wire readyEvent = convActive && cfg.readyIntEnable &&
        (cfg.sequential ? allSeen : 1'b1);
    wire [3:0] next_seenMask = (readyEvent || !cfg.sequential) ? 4'h0 : next_seenCombined;
    wire next_ready = readyEvent || (result_ready_flag && !statusRead);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            errFlags <= 6'h00;
            error_source_channel <= 2'h0;
            result_ready_flag <= 1'b0;
            seenMask <= 4'h0;
        end else begin
            errFlags <= next_errFlags;
            error_source_channel <= next_chan;
            result_ready_flag <= next_ready;
            seenMask <= next_seenMask;
        end
    end

    csf_pending_bits u_pending (
        .ref_clk(ref_clk),
        .reset(reset),
        .setMask(convSetMask),
        .clearMask(resultReadMask),
        .pending(pendingBits)
    );

    // Reserved bits 7, 5:4 are tied low; channel bit order is reversed in the word
    assign conversion_status = {error_source_channel, errFlags, 1'b0, result_ready_flag,
        2'b00, pendingBits[0], pendingBits[1], pendingBits[2], pendingBits[3]};
    // Amplitude-high is reported so software can trim drive current
    assign irq_out_n = ~(|errFlags || result_ready_flag);

    a_error_latch: assert property (@(posedge ref_clk) disable iff (reset)
        errFlags[5] && !releaseErr |=> conversion_status[`CSF_UR_BIT])
        else $error("under-range dropped early");

    a_latch_hold: assert property (@(posedge ref_clk) disable iff (reset)
        |errFlags && !releaseErr |=> (conversion_status[13:8] & $past(errFlags)) == $past(errFlags))
        else $error("latched error dropped");

    a_source_release: assert property (@(posedge ref_clk) disable iff (reset)
        resultRead && readChan == error_source_channel && !anyNewErr |=> conversion_status[13:8] == 6'h00)
        else $error("source result read did not release");

    a_other_read_keeps: assert property (@(posedge ref_clk) disable iff (reset)
        resultRead && readChan != error_source_channel && |errFlags |=> conversion_status[13:8] != 6'h00)
        else $error("other channel read released errors");

    a_status_clear: assert property (@(posedge ref_clk) disable iff (reset)
        statusRead && !anyNewErr |=> conversion_status[13:8] == 6'h00)
        else $error("status read did not clear");

    a_clear_keeps_new: assert property (@(posedge ref_clk) disable iff (reset)
        statusRead && anyNewErr |=> conversion_status[13:8] == $past(newErr))
        else $error("new error lost on status read");

    a_under_set: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[5] && cfg.errIntEnable[5] |=>
        conversion_status[`CSF_UR_BIT]) else $error("under-range missed");

    a_over_range: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[4] && cfg.errIntEnable[4] |=>
        conversion_status[`CSF_OR_BIT]) else $error("over-range missed");

    a_timeout_set: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[3] && cfg.errIntEnable[3] |=>
        conversion_status[`CSF_WD_BIT]) else $error("timeout missed");

    a_amp_high_set: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[2] && cfg.errIntEnable[2] |=>
        conversion_status[`CSF_AH_BIT]) else $error("amplitude high missed");

    a_amp_low_set: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[1] && cfg.errIntEnable[1] |=>
        conversion_status[`CSF_AL_BIT]) else $error("amplitude low missed");

    a_zero_count_set: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.errors[0] && cfg.errIntEnable[0] |=>
        conversion_status[`CSF_ZC_BIT]) else $error("zero count missed");

    a_inactive_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        conv.valid && !cfg.activeMask[conv.channel] && errFlags == 6'h00 |=>
        conversion_status[13:8] == 6'h00) else $error("inactive channel error recorded");

    a_gate_under: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.errIntEnable[5] && !errFlags[5] |=>
        !conversion_status[`CSF_UR_BIT]) else $error("disabled under-range set");

    a_gate_over: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.errIntEnable[4] && !errFlags[4] |=>
        !conversion_status[`CSF_OR_BIT]) else $error("disabled over-range set");

    a_gate_timeout: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.errIntEnable[3] && !errFlags[3] |=>
        !conversion_status[`CSF_WD_BIT]) else $error("disabled timeout set");

    a_gate_amp_high: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.errIntEnable[2] && !errFlags[2] |=>
        !conversion_status[`CSF_AH_BIT]) else $error("disabled amplitude high set");

    a_gate_amp_low: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.errIntEnable[1] && !errFlags[1] |=>
        !conversion_status[`CSF_AL_BIT]) else $error("disabled amplitude low set");

    a_gate_disabled: assert property (@(posedge ref_clk) disable iff (reset)
        conv.valid && conv.errors[0] && !cfg.errIntEnable[0] && !errFlags[0] |=>
        !conversion_status[`CSF_ZC_BIT]) else $error("disabled zero count set");

    a_ready_single: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && !cfg.sequential && cfg.readyIntEnable |=>
        conversion_status[`CSF_RDY_BIT]) else $error("ready missing");

    a_ready_hold: assert property (@(posedge ref_clk) disable iff (reset)
        result_ready_flag && !statusRead |=>
        conversion_status[`CSF_RDY_BIT]) else $error("ready dropped early");

    a_ready_clear: assert property (@(posedge ref_clk) disable iff (reset)
        statusRead && !readyEvent |=>
        !conversion_status[`CSF_RDY_BIT]) else $error("ready not cleared");

    a_seq_wait: assert property (@(posedge ref_clk) disable iff (reset)
        cfg.sequential && !result_ready_flag && !allSeen |=>
        !conversion_status[`CSF_RDY_BIT]) else $error("ready before all channels");

    a_seq_ready: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && cfg.sequential && cfg.readyIntEnable && allSeen |=>
        conversion_status[`CSF_RDY_BIT]) else $error("sequential ready missing");

    a_seen_clear: assert property (@(posedge ref_clk) disable iff (reset)
        readyEvent |=> seenMask == 4'h0)
        else $error("channel tracking not restarted");

    a_ready_gated: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.readyIntEnable && !result_ready_flag |=> !conversion_status[`CSF_RDY_BIT])
        else $error("ready without enable");

    a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(conversion_status[`CSF_RDY_BIT]) |-> !irq_out_n)
        else $error("irq not asserted");

    a_irq_error: assert property (@(posedge ref_clk) disable iff (reset)
        |errFlags |-> !irq_out_n)
        else $error("irq missing for error");

    a_irq_idle: assert property (@(posedge ref_clk) disable iff (reset)
        errFlags == 6'h00 && !result_ready_flag |-> irq_out_n)
        else $error("irq without cause");

    a_pending_ch0: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.channel == 2'h0 |=> conversion_status[3])
        else $error("channel 0 unread bit missing");

    a_pending_ch3: assert property (@(posedge ref_clk) disable iff (reset)
        convActive && conv.channel == 2'h3 |=> conversion_status[0])
        else $error("channel 3 unread bit missing");

    a_inactive_no_pend: assert property (@(posedge ref_clk) disable iff (reset)
        conv.valid && !cfg.activeMask[conv.channel] && !rd.valid |=>
        $stable(conversion_status[3:0])) else $error("inactive channel marked unread");

    a_read_clear_ch0: assert property (@(posedge ref_clk) disable iff (reset)
        resultRead && readChan == 2'h0 && !(convActive && conv.channel == 2'h0) |=>
        !conversion_status[3]) else $error("channel 0 unread bit not cleared");

    a_read_clear_ch2: assert property (@(posedge ref_clk) disable iff (reset)
        resultRead && readChan == 2'h2 && !(convActive && conv.channel == 2'h2) |=>
        !conversion_status[1]) else $error("channel 2 unread bit not cleared");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
        conversion_status[7] == 1'b0 && conversion_status[5:4] == 2'b00)
        else $error("reserved bits nonzero");

    a_chan_capture: assert property (@(posedge ref_clk) disable iff (reset)
        anyNewErr && errFlags == 6'h00 |=> conversion_status[15:14] == $past(conv.channel))
        else $error("source channel wrong");

    a_chan_hold: assert property (@(posedge ref_clk) disable iff (reset)
        |errFlags && !releaseErr |=> $stable(conversion_status[15:14]))
        else $error("source channel moved while latched");
endmodule : conversion_status_flags

// *** dv/csf_host_model.sv ***
module csf_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register reads toward the device
    output csf_pkg::csf_read_t rd
);
    timeunit 1ns;
    timeprecision 1ps;
    import csf_pkg::*;
    int seed = 32'ha6f3;
    int pick;
    initial rd = '0;
    // One-cycle read pulses; idle address toggles so stale values never look valid
    always @(negedge ref_clk) begin
        pick = $unsigned($random(seed)) % 24;
        rd.valid <= !reset && pick < 6;
        rd.addr <= (pick == 4) ? 8'h18 : (pick == 5) ? 8'h05 : (pick < 4) ? 8'(pick) : ~rd.addr;
    end
endmodule : csf_host_model

// *** dv/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import csf_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    csf_conv_t conv = '0;
    csf_read_t rd;
    csf_cfg_t cfg = '0;
    logic [15:0] conversion_status;
    logic irqOutN;
    logic [15:0] careMask;
    int err_count = 0;
    int total_checks = 0;
    int seed = 32'ha6f3;
    int errs, chan, rdy, pend, seen;
    always #5 ref_clk = ~ref_clk;
    conversion_status_flags u_conversion_status_flags (.ref_clk(ref_clk), .reset(reset),
        .conv(conv), .rd(rd), .cfg(cfg), .conversion_status(conversion_status),
        .irq_out_n(irqOutN));
    csf_host_model u_csf_host_model (.ref_clk(ref_clk), .reset(reset), .rd(rd));
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (exp !== got) begin
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
            err_count++;
        end
    endtask : check
    // Reference model; clears are applied before sets so a new event wins
    always @(posedge ref_clk) begin
        if (reset) begin
            {errs, chan, rdy, pend, seen} = '0;
        end else begin
            if (rd.valid && rd.addr == 8'h18) {errs, rdy} = '0;
            if (rd.valid && rd.addr < 8'h04) begin
                pend &= ~(8 >> rd.addr);
                if (rd.addr == chan) errs = 0;
            end
            if (conv.valid && cfg.activeMask[conv.channel]) begin
                pend |= 8 >> conv.channel;
                if ((conv.errors & cfg.errIntEnable) != 0 && errs == 0) chan = conv.channel;
                errs |= conv.errors & cfg.errIntEnable;
                seen |= 1 << conv.channel;
                if (cfg.readyIntEnable && (!cfg.sequential
                    || (seen & cfg.activeMask) == cfg.activeMask)) begin
                    rdy = 1;
                    seen = 0;
                end
            end
        end
    end
    initial begin
        // Phase 0 single-channel, phase 1 sequential; reset between them
        for (int ph = 0; ph < 2; ph++) begin
            reset = 1'b1;
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            reset = 1'b0;
            cfg.sequential = ph[0];
            cfg.activeMask = 4'($random(seed)) | 4'h1;
            repeat (3000) begin
                @(negedge ref_clk);
                // Channel code is only meaningful while an error is latched
                careMask = (errs != 0) ? 16'hFFFF : 16'h3FFF;
                check({chan[1:0], errs[5:0], 1'b0, rdy[0], 2'h0, pend[3:0]} & careMask, conversion_status & careMask);
                check({15'h0, !(errs != 0 || rdy != 0)}, {15'h0, irqOutN});
                conv.channel = 2'($random(seed));
                // Inactive channels are sent too so the activity gate is exercised
                conv.valid = 1'($random(seed));
                conv.errors = ($random(seed) % 3 == 0) ? 6'($random(seed)) : 6'h00;
                // Host has lowered drive current on the channel flagged amplitude-high
                if (errs[2] && conv.channel == chan[1:0]) conv.errors[2] = 1'b0;
                cfg.errIntEnable = 6'($random(seed));
                cfg.readyIntEnable = ph[0] | $random(seed);
            end
        end
        report_and_stop;
    end
endmodule : testbench
